// >>> shared/dma_xfer_defs.vh
// offsets, field layouts and encodings of the dma channel transfer control
// included by the register file and engine; definitions only
`ifndef DMA_XFER_DEFS_VH
`define DMA_XFER_DEFS_VH

// byte offsets of the register words
`define OFS_CTRL        6'h00
`define OFS_MODE_PRI    6'h04
`define OFS_MODE_ALT    6'h08
`define OFS_COUNT_PRI   6'h0c
`define OFS_COUNT_ALT   6'h10
`define OFS_STATUS      6'h14
`define OFS_ID          6'h18

// control word fields
`define CTRL_CHAN_LSB   0
`define CTRL_CHAN_W     4
`define CTRL_ENABLE     4
`define CTRL_SWREQ      5
`define CTRL_ALTSEL     6
`define CTRL_SECOND     7
`define CTRL_ARB_LSB    8
`define CTRL_ARB_W      4

// mode encodings, three bits
`define MODE_HALTED         3'h0
`define MODE_REQUEST_DRIVEN 3'h1
`define MODE_RUN_TO_END     3'h2
`define MODE_DOUBLE_BUFFER  3'h3
`define MODE_MEM_LIST_PRI   3'h4
`define MODE_MEM_LIST_ALT   3'h5
`define MODE_PER_LIST_PRI   3'h6
`define MODE_PER_LIST_ALT   3'h7

`define COUNT_W         11
`define ARB_MAX_LOG2    4'ha
`define RD_UNMAPPED     32'h0000_0000

`endif

// >>> src/dma_channel_transfer_control.v
// dma channel transfer control: per-channel modes, counts, enables, requests
// assumes an avalon-mm master on the register side and peripherals that
// hold their request level while they want items moved
//
// Design decisions made here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "dma_xfer_defs.vh"

module dma_channel_transfer_control #(
  parameter NCH     = 15,
  parameter SW_CH   = 14,
  parameter ID_CODE = 32'h0000_5a01  // arbitrary value
) (
  input  wire            core_clk,
  input  wire            rst_b,
  input  wire [5:0]      avs_address,
  input  wire            avs_read,
  input  wire            avs_write,
  input  wire [31:0]     avs_writedata,
  input  wire [3:0]      avs_byteenable,
  output reg  [31:0]     avs_readdata,
  output wire            avs_waitrequest,
  input  wire [NCH-1:0]  primary_req,
  input  wire [NCH-1:0]  alternate_req,
  input  wire            item_ready,
  output reg             item_move_ff,
  output reg  [3:0]      item_chan_ff,
  output reg             rearb_ff,
  output reg  [NCH-1:0]  periph_done_ff,
  output reg             sw_done_irq_ff
);

  // per-channel state in flip-flops, indexed by channel number
  reg [2:0]            mode_pri_ff   [0:NCH-1];
  reg [2:0]            mode_alt_ff   [0:NCH-1];
  reg [`COUNT_W-1:0]   cnt_pri_ff    [0:NCH-1];
  reg [`COUNT_W-1:0]   cnt_alt_ff    [0:NCH-1];
  reg [NCH-1:0]        enable_ff;
  reg [NCH-1:0]        use_alt_ff;
  reg [NCH-1:0]        second_ff;
  reg [NCH-1:0]        swreq_ff;
  reg [NCH-1:0]        running_ff;
  reg [3:0]            arb_ff        [0:NCH-1];
  reg [3:0]            sel_ff;
  reg                  ack_ff;
  reg [10:0]           burst_ff;

  // burst_ff counts items since the last arbitration point
  // one-hot engine states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_MOVE = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;
  // cur_ff holds the channel being served while not idle
  reg [2:0] state_ff;
  reg [3:0] cur_ff;

  wire       bus_req = avs_read | avs_write;
  // one wait cycle, answer on the second edge of the request
  assign avs_waitrequest = bus_req & ~ack_ff;
  // write lands only on the answer edge, never on the wait edge
  wire       wr_go = avs_write & ack_ff;
  // reads need no strobe: the mux below is steady while the request
  // is held, so the master takes data on the edge waitrequest is low
  wire [3:0] sel_ch = sel_ff;

  // a channel may only be served once enabled; the enable also masks
  // both peripheral lines and any pending software request, so a
  // disabled channel looks silent to the picker
  // effective request per channel: peripheral by assignment, or software
  reg [NCH-1:0] req_eff;
  integer k;
  always @* begin
    for (k = 0; k < NCH; k = k + 1) begin
      req_eff[k] = enable_ff[k] &
                   (swreq_ff[k] |
                    (second_ff[k] ? alternate_req[k] : primary_req[k]));
    end
  end

  // fixed priority keeps the picker small; a busy low channel in
  // request-driven mode can hold off higher channels between items,
  // which is the price of not keeping a round-robin pointer
  // first requesting channel, lowest number wins
  reg [3:0] pick;
  reg       pick_v;
  integer j;
  always @* begin
    pick = 4'h0;
    pick_v = 1'b0;
    for (j = NCH - 1; j >= 0; j = j - 1) begin
      if (req_eff[j] | (running_ff[j] & enable_ff[j])) begin
        pick = j[3:0];
        pick_v = 1'b1;
      end
    end
  end

  // view of the channel being served, through whichever structure
  // it currently uses; all engine decisions read these
  wire                cur_alt   = use_alt_ff[cur_ff];
  wire [2:0]          cur_mode  = cur_alt ? mode_alt_ff[cur_ff] : mode_pri_ff[cur_ff];
  wire [`COUNT_W-1:0] cur_cnt   = cur_alt ? cnt_alt_ff[cur_ff] : cnt_pri_ff[cur_ff];
  wire [10:0]         arb_len   = 11'h1 << arb_ff[cur_ff];
  // request-driven moves only while requested, others hold on once started
  wire cur_may = (cur_mode == `MODE_REQUEST_DRIVEN) ? req_eff[cur_ff] :
                 (running_ff[cur_ff] | req_eff[cur_ff]);
  wire last_item = (cur_cnt == {{(`COUNT_W-1){1'b0}}, 1'b1});

  // reads never have side effects, so a held read is harmless
  // register read mux; the inactive structure reads back as stored, halted or not
  always @* begin
    case (avs_address)
      `OFS_CTRL: avs_readdata = {20'h0, arb_ff[sel_ch], second_ff[sel_ch], use_alt_ff[sel_ch],
                                 swreq_ff[sel_ch], enable_ff[sel_ch], sel_ch};
      `OFS_MODE_PRI:  avs_readdata = {29'h0, mode_pri_ff[sel_ch]};
      `OFS_MODE_ALT:  avs_readdata = {29'h0, mode_alt_ff[sel_ch]};
      `OFS_COUNT_PRI: avs_readdata = {21'h0, cnt_pri_ff[sel_ch]};
      `OFS_COUNT_ALT: avs_readdata = {21'h0, cnt_alt_ff[sel_ch]};
      `OFS_STATUS:    avs_readdata = {17'h0, running_ff};
      `OFS_ID:        avs_readdata = ID_CODE;
      default:        avs_readdata = `RD_UNMAPPED;
    endcase
  end

  // bus handshake and channel select
  // ack_ff toggles once per request, so every access costs two edges
  // and back-to-back requests still see a fresh wait cycle
  always @(posedge core_clk) begin
    if (!rst_b) begin
      ack_ff <= 1'b0;
      sel_ff <= 4'h0;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
      if (wr_go && avs_address == `OFS_CTRL && avs_byteenable[0])
        sel_ff <= avs_writedata[`CTRL_CHAN_LSB +: `CTRL_CHAN_W];
    end
  end

  // software and engine share these flip-flops; the engine writes
  // later in the same process, so its update lands when both
  // touch one field in one cycle, except swreq_ff, which is set again below
  // channel state: software writes and engine updates; engine wins a tie except on the software request, where the set wins
  integer c;
  always @(posedge core_clk) begin
    if (!rst_b) begin
      // all registered outputs low and no channel enabled after reset
      for (c = 0; c < NCH; c = c + 1) begin
        mode_pri_ff[c] <= `MODE_HALTED;
        mode_alt_ff[c] <= `MODE_HALTED;
        cnt_pri_ff[c]  <= {`COUNT_W{1'b0}};
        cnt_alt_ff[c]  <= {`COUNT_W{1'b0}};
        arb_ff[c]      <= 4'h0;
      end
      enable_ff      <= {NCH{1'b0}};
      use_alt_ff     <= {NCH{1'b0}};
      second_ff      <= {NCH{1'b0}};
      swreq_ff       <= {NCH{1'b0}};
      running_ff     <= {NCH{1'b0}};
      state_ff       <= ST_IDLE;
      cur_ff         <= 4'h0;
      burst_ff       <= 11'h0;
      item_move_ff   <= 1'b0;
      item_chan_ff   <= 4'h0;
      rearb_ff       <= 1'b0;
      periph_done_ff <= {NCH{1'b0}};
      sw_done_irq_ff <= 1'b0;
    end else begin
      // pulse outputs default low each edge; item_chan_ff keeps the last channel
      item_move_ff   <= 1'b0;
      rearb_ff       <= 1'b0;
      periph_done_ff <= {NCH{1'b0}};
      sw_done_irq_ff <= 1'b0;
      // software writes to the selected channel
      if (wr_go && sel_ch < NCH) begin
        case (avs_address)
          `OFS_CTRL: begin
            if (avs_byteenable[0]) begin
              enable_ff[sel_ch]  <= avs_writedata[`CTRL_ENABLE];
              use_alt_ff[sel_ch] <= avs_writedata[`CTRL_ALTSEL];
              second_ff[sel_ch]  <= avs_writedata[`CTRL_SECOND];
              if (avs_writedata[`CTRL_SWREQ])
                swreq_ff[sel_ch] <= 1'b1;
            end
            // sizes above the largest block are clipped, not wrapped
            if (avs_byteenable[1])
              arb_ff[sel_ch] <= (avs_writedata[`CTRL_ARB_LSB +: `CTRL_ARB_W] > `ARB_MAX_LOG2) ?
                                `ARB_MAX_LOG2 : avs_writedata[`CTRL_ARB_LSB +: `CTRL_ARB_W];
          end
          // list codes are folded onto the structure's own code
          `OFS_MODE_PRI:  if (avs_byteenable[0])
            mode_pri_ff[sel_ch] <= (avs_writedata[2:0] == `MODE_MEM_LIST_ALT) ? `MODE_MEM_LIST_PRI :
                                   (avs_writedata[2:0] == `MODE_PER_LIST_ALT) ? `MODE_PER_LIST_PRI :
                                   avs_writedata[2:0];
          `OFS_MODE_ALT:  if (avs_byteenable[0])
            mode_alt_ff[sel_ch] <= (avs_writedata[2:0] == `MODE_MEM_LIST_PRI) ? `MODE_MEM_LIST_ALT :
                                   (avs_writedata[2:0] == `MODE_PER_LIST_PRI) ? `MODE_PER_LIST_ALT :
                                   avs_writedata[2:0];
          // counts need both low lanes so a half-written count never
          // starts a transfer
          `OFS_COUNT_PRI: if (avs_byteenable[1:0] == 2'b11)
            cnt_pri_ff[sel_ch] <= avs_writedata[`COUNT_W-1:0];
          `OFS_COUNT_ALT: if (avs_byteenable[1:0] == 2'b11)
            cnt_alt_ff[sel_ch] <= avs_writedata[`COUNT_W-1:0];
          default: ;
        endcase
      end
      // engine sequencing
      case (state_ff)
        ST_IDLE: begin
          if (pick_v) begin
            cur_ff   <= pick;
            burst_ff <= 11'h0;
            state_ff <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          // a channel disabled or halted under the engine is dropped
          // cleanly instead of moving a stray item
          if (!enable_ff[cur_ff] || cur_mode == `MODE_HALTED || cur_cnt == {`COUNT_W{1'b0}}) begin
            running_ff[cur_ff] <= 1'b0;
            swreq_ff[cur_ff]   <= 1'b0;
            state_ff <= ST_IDLE;
          end else if (!cur_may) begin
            state_ff <= ST_IDLE;
          // memory side back-pressure stalls without losing the slot
          end else if (item_ready) begin
            running_ff[cur_ff] <= 1'b1;
            swreq_ff[cur_ff]   <= 1'b0;
            item_move_ff <= 1'b1;
            item_chan_ff <= cur_ff;
            if (cur_alt)
              cnt_alt_ff[cur_ff] <= cur_cnt - 1'b1;
            else
              cnt_pri_ff[cur_ff] <= cur_cnt - 1'b1;
            // the last item goes to the done step, never to rearbitration
            if (last_item) begin
              state_ff <= ST_DONE;
            end else if (burst_ff + 11'h1 == arb_len) begin
              rearb_ff <= 1'b1;
              state_ff <= ST_IDLE;
            end else begin
              burst_ff <= burst_ff + 11'h1;
            end
          end
        end
        ST_DONE: begin
          // count already zero here
          if (cur_alt)
            mode_alt_ff[cur_ff] <= `MODE_HALTED;
          else
            mode_pri_ff[cur_ff] <= `MODE_HALTED;
          // double buffer and list modes hand over to the other
          // structure; the channel only drops out once both are halted
          if (cur_mode == `MODE_DOUBLE_BUFFER ||
              cur_mode[2] == 1'b1) begin
            use_alt_ff[cur_ff] <= ~cur_alt;
            if ((cur_alt ? mode_pri_ff[cur_ff] : mode_alt_ff[cur_ff]) == `MODE_HALTED) begin
              enable_ff[cur_ff]  <= 1'b0;
              running_ff[cur_ff] <= 1'b0;
            end
          end else begin
            enable_ff[cur_ff]  <= 1'b0;
            running_ff[cur_ff] <= 1'b0;
          end
          // software channel has its own line, peripherals their own
          if (cur_ff == SW_CH[3:0])
            sw_done_irq_ff <= 1'b1;
          else
            periph_done_ff[cur_ff] <= 1'b1;
          state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
      // a request written in the cycle the engine consumes the
      // previous one must not be lost: the set wins over the clear
      if (wr_go && sel_ch < NCH && avs_address == `OFS_CTRL && avs_byteenable[0] &&
          avs_writedata[`CTRL_SWREQ])
        swreq_ff[sel_ch] <= 1'b1;
    end
  end

endmodule // dma_channel_transfer_control

// >>> tb/dma_xfer_ctl_props.sv
// port assertions for the dma channel transfer control block
// assumes one clock core_clk and synchronous active-low rst_b
`timescale 1ns/1ps
module dma_xfer_ctl_props #(
  parameter NCH   = 15,
  parameter SW_CH = 14
) (
  input wire            core_clk,
  input wire            rst_b,
  input wire [5:0]      avs_address,
  input wire            avs_read,
  input wire            avs_write,
  input wire [31:0]     avs_readdata,
  input wire            avs_waitrequest,
  input wire            item_move_ff,
  input wire [3:0]      item_chan_ff,
  input wire            rearb_ff,
  input wire [NCH-1:0]  periph_done_ff,
  input wire            sw_done_irq_ff
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // bus holds off one cycle, then answers
  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("waitrequest low on new request");
  a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held past one cycle");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 6'h18
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_chan_valid: assert property (item_move_ff |-> item_chan_ff < NCH)
    else $error("item on missing channel");
  a_irq_pulse: assert property (sw_done_irq_ff |=> !sw_done_irq_ff)
    else $error("software done longer than a cycle");
  a_periph_done: assert property ($onehot0(periph_done_ff) && !periph_done_ff[SW_CH])
    else $error("bad peripheral done");
  // completion only closes a run of moved items
  a_done_item: assert property ((sw_done_irq_ff || |periph_done_ff) |->
    $past(item_move_ff) || $past(item_move_ff, 2) || $past(item_move_ff, 3)) else $error("done w/o item");
  a_rearb_item: assert property (rearb_ff |-> item_move_ff || $past(item_move_ff))
    else $error("rearbitration without item");
endmodule // dma_xfer_ctl_props

bind dma_channel_transfer_control dma_xfer_ctl_props #(.NCH(NCH), .SW_CH(SW_CH)) i_props (
  .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .item_move_ff(item_move_ff), .item_chan_ff(item_chan_ff), .rearb_ff(rearb_ff),
  .periph_done_ff(periph_done_ff), .sw_done_irq_ff(sw_done_irq_ff));

// >>> tb/periph_mem_model.sv
// peripheral request lines and memory ready for the transfer block
// assumes the bench names the wanted request levels; one clock
`timescale 1ns/1ps
module periph_mem_model (
  input  wire        core_clk,
  input  wire        rst_b,
  input  wire        slow,
  input  wire [14:0] want_pri,
  input  wire [14:0] want_alt,
  output reg  [14:0] primary_req,
  output reg  [14:0] alternate_req,
  output reg         item_ready
);
  // only request levels and memory readiness are modelled, no data moves
  // requests held as levels; slow memory accepts every other cycle
  always @(posedge core_clk) begin
    if (!rst_b) begin
      primary_req   <= 15'h0;
      alternate_req <= 15'h0;
      item_ready    <= 1'b0;
    end else begin
      primary_req   <= want_pri;
      alternate_req <= want_alt;
      item_ready    <= slow ? ~item_ready : 1'b1;
    end
  end
endmodule // periph_mem_model

// >>> tb/testbench.sv
// self-checking bench for the dma channel transfer control block
// assumes the partner model drives requests and memory ready
`timescale 1ns/1ps
module testbench;
  logic        core_clk, rst_b, avs_read, avs_write, slow, avs_waitrequest;
  logic        item_ready, item_move_ff, rearb_ff, sw_done_irq_ff;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  item_chan_ff;
  logic [14:0] primary_req, alternate_req, want_pri, want_alt, periph_done_ff;
  int          errors, checked, moves, rearbs, sw_dn, p_dn, m, i, last_ch;

  dma_channel_transfer_control i_dma_channel_transfer_control (
    .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .primary_req(primary_req), .alternate_req(alternate_req), .item_ready(item_ready),
    .item_move_ff(item_move_ff), .item_chan_ff(item_chan_ff), .rearb_ff(rearb_ff),
    .periph_done_ff(periph_done_ff), .sw_done_irq_ff(sw_done_irq_ff));
  periph_mem_model i_periph_mem_model (
    .core_clk(core_clk), .rst_b(rst_b), .slow(slow), .want_pri(want_pri),
    .want_alt(want_alt), .primary_req(primary_req), .alternate_req(alternate_req),
    .item_ready(item_ready));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // event tallies read back by the scenarios
  always @(posedge core_clk) begin
    if (item_move_ff === 1'b1) begin
      moves <= moves + 1;
      last_ch <= item_chan_ff;
    end
    if (rearb_ff === 1'b1) rearbs <= rearbs + 1;
    if (sw_done_irq_ff === 1'b1) sw_dn <= sw_dn + 1;
    if (|periph_done_ff === 1'b1) p_dn <= p_dn + 1;
  end

  task automatic conclude;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one avalon access; held until the rising edge that sees waitrequest
  // low, readdata taken at that edge, released right after it
  task automatic bus(input logic r, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= r;
    avs_write <= !r;
    do begin
      @(posedge core_clk);
      n++;
      if (n > 40) begin
        errors++;
        conclude();
      end
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] e, input string w);
    bus(1'b1, a, 32'h0);
    chk(q, e, w);
  endtask

  // bounded wait on completions (dn) or moved items
  task automatic wait_until(input bit dn, input int t);
    int n;
    for (n = 0; (dn ? sw_dn + p_dn : moves) < t; n++) begin
      if (n > 400) begin
        errors++;
        conclude();
      end
      @(posedge core_clk);
    end
    repeat (3) @(posedge core_clk);
  endtask

  initial begin
    rst_b = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    slow = 1'b1;
    want_pri = 15'h0;
    want_alt = 15'h0;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    chk({item_move_ff, rearb_ff, sw_done_irq_ff, periph_done_ff}, 0, "idle outputs");
    rd(6'h3c, 32'h0, "unmapped");
    wr(6'h00, 32'h5);
    for (i = 0; i < 8; i++) begin
      wr(6'h04, i);
      rd(6'h04, (i == 5 || i == 7) ? i - 1 : i, "mode primary");
      wr(6'h08, i);
      rd(6'h08, (i == 4 || i == 6) ? i + 1 : i, "mode alternate");
    end
    // software channel, run to end, four items, slow memory
    wr(6'h00, 32'h10e);
    wr(6'h04, 32'h2);
    wr(6'h0c, 32'h4);
    wr(6'h00, 32'h11e);
    wr(6'h00, 32'h13e);
    wait_until(1, 1);
    chk(moves, 4, "items auto");
    chk(rearbs, 1, "rearbitrations");
    chk(last_ch, 14, "item channel");
    chk(sw_dn, 1, "software done");
    chk(p_dn, 0, "peripheral done");
    rd(6'h04, 32'h0, "mode after end");
    rd(6'h0c, 32'h0, "count after end");
    // request-driven channel stops when its request drops
    slow <= 1'b0;
    wr(6'h00, 32'h0);
    wr(6'h04, 32'h1);
    wr(6'h0c, 32'h8);
    wr(6'h00, 32'h10);
    want_pri <= 15'h1;
    wait_until(0, 5);
    want_pri <= 15'h0;
    repeat (8) @(posedge core_clk);
    m = moves - 4;
    repeat (8) @(posedge core_clk);
    chk(moves - 4, m, "paused items");
    rd(6'h0c, 8 - m, "remaining count");
    want_pri <= 15'h3;
    wait_until(1, 2);
    repeat (10) @(posedge core_clk);
    chk(moves, 12, "disabled ignores");
    rd(6'h14, 32'h0, "running bits");
    // secondary assignment shuts out the default peripheral
    wr(6'h00, 32'h82);
    wr(6'h04, 32'h1);
    wr(6'h0c, 32'h2);
    wr(6'h00, 32'h92);
    want_pri <= 15'h7;
    repeat (10) @(posedge core_clk);
    chk(moves, 12, "default blocked");
    want_alt <= 15'h4;
    wait_until(1, 3);
    chk(moves, 14, "items secondary");
    // double buffer runs primary then alternate
    wr(6'h00, 32'h3);
    wr(6'h04, 32'h3);
    wr(6'h0c, 32'h2);
    wr(6'h08, 32'h3);
    wr(6'h10, 32'h2);
    wr(6'h00, 32'h13);
    want_pri <= 15'h8;
    wait_until(1, 5);
    chk(moves, 18, "items double buffer");
    rd(6'h04, 32'h0, "primary halted");
    rd(6'h08, 32'h0, "alternate halted");
    conclude();
  end
endmodule // testbench
